//--- rtl/esie_core.sv
// esie_core: executes the four extended software-stack instructions
// Behaviour
// - move addresses are pointer two plus offsets
// - addresses span the full 12-bit data space
// - move to pc low or stack top refused
// - indirect-register source reads as zero
// - indirect-register destination: no write, nop
// - move reads cycle one, writes cycle two
// - push writes literal at pointer two
// - push then decrements pointer two by one
// - subtract literal from selected pointer, one cycle
// - subtract-and-return subtracts and loads pc on the same edge
// - return form takes two cycles, select 11
`timescale 1ns/100ps
module esie_core (
  input  wire logic        mclk_in,      // instruction clock, 50 MHz
  input  wire logic        rstn_in,      // async reset, active low
  input  wire logic        instr_vld_in, // fetched word valid this cycle
  input  wire logic [15:0] instr_in,     // fetched program word
  input  wire logic [7:0]  rd_data_in,   // data memory read data
  input  wire logic [20:0] stack_top_in, // return_stack_top value
  output logic [11:0]      rd_addr_out,  // data memory read address
  output logic             rd_en_out,    // data memory read strobe
  output logic [11:0]      wr_addr_out,  // data memory write address
  output logic [7:0]       wr_data_out,  // data memory write data
  output logic             wr_en_out,    // data memory write strobe
  output logic [11:0]      ptr0_out,     // indirect pointer zero
  output logic [11:0]      ptr1_out,     // indirect pointer one
  output logic [11:0]      ptr2_out,     // indirect_pointer_two
  output logic [20:0]      pc_load_out,  // new program counter
  output logic             pc_load_en_out, // pc load pulse
  output logic             flags_we_out, // status flag write, always low
  output logic             busy_out      // second cycle in progress
);
  esie_pkg::esie_state_t state;          // execution phase
  logic [11:0] ptr [3];                  // the three indirect pointers
  logic [7:0]  src_byte;                 // source byte: read data, or zero if indirect
  logic        src_ind;                  // source was indirect register
  logic [11:0] src_addr;                 // computed move source
  logic [11:0] dst_addr;                 // computed move destination
  logic        dst_ind;                  // destination is indirect register
  logic        dst_bad;                  // destination is forbidden register
  logic        is_move, is_push, is_sub; // first-cycle decode
  logic [1:0]  sel;                      // pointer select field
  logic [11:0] lit6;                     // zero extended 6-bit literal
  logic        idle;                     // ready to decode

  assign idle    = (state == esie_pkg::ESIE_IDLE);
  assign is_move = idle && instr_vld_in &&
                   (instr_in[15:7] == esie_pkg::OP_IDX_MOVE);
  assign is_push = idle && instr_vld_in &&
                   (instr_in[15:8] == esie_pkg::OP_PUSH_LIT);
  assign is_sub  = idle && instr_vld_in &&
                   (instr_in[15:8] == esie_pkg::OP_SUB_PTR);
  assign sel     = instr_in[7:6];
  assign lit6    = {6'h00, instr_in[5:0]};

  // address forming, wraps in the 12-bit space
  assign src_addr = ptr[2] + {5'h00, instr_in[6:0]};
  assign dst_addr = ptr[2] + {5'h00, instr_in[6:0]};

  assign dst_bad = (dst_addr == esie_pkg::ADDR_PC_LOW)    ||
                   (dst_addr == esie_pkg::ADDR_TOP_LOW)   ||
                   (dst_addr == esie_pkg::ADDR_TOP_HIGH)  ||
                   (dst_addr == esie_pkg::ADDR_TOP_UPPER);

  esie_ind_detect u_src_ind (
    .addr_in (src_addr),
    .hit_out (src_ind)
  );
  esie_ind_detect u_dst_ind (
    .addr_in (dst_addr),
    .hit_out (dst_ind)
  );

  logic src_ind_q;                       // source indirect, held to cycle 2

  // phase sequencing
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= esie_pkg::ESIE_IDLE;
    end else begin
      case (state)
        esie_pkg::ESIE_IDLE: begin
          if (is_move) begin
            state <= esie_pkg::ESIE_MOVE;
          // return form adds a dead cycle
          end else if (is_sub && sel == esie_pkg::SEL_RETURN) begin
            state <= esie_pkg::ESIE_RET;
          end
        end
        default: begin
          state <= esie_pkg::ESIE_IDLE;  // move and ret both end here
        end
      endcase
    end
  end

  // source read at end of first move cycle
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_en_out   <= 1'b0;
      rd_addr_out <= esie_pkg::ADDR_ZERO;
      src_ind_q   <= 1'b0;
    end else begin
      rd_en_out <= is_move && !src_ind;
      if (is_move) begin
        rd_addr_out <= src_addr;
        src_ind_q   <= src_ind;
      end
    end
  end

  // indirect source supplies zero instead of memory data
  assign src_byte = src_ind_q ? esie_pkg::DATA_ZERO : rd_data_in;

  // data memory writes: push in one cycle, move in its second
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_en_out   <= 1'b0;
      wr_addr_out <= esie_pkg::ADDR_ZERO;
      wr_data_out <= esie_pkg::DATA_ZERO;
    end else begin
      wr_en_out <= 1'b0;
      if (is_push) begin
        wr_en_out   <= 1'b1;
        wr_addr_out <= ptr[2];
        wr_data_out <= instr_in[7:0];
      // second word carries the 1111 prefix and the destination offset
      end else if (state == esie_pkg::ESIE_MOVE) begin
        // indirect or forbidden destination: nothing written
        // destination written at end of second cycle
        wr_en_out   <= !dst_ind && !dst_bad &&
                       (instr_in[15:12] == esie_pkg::OP_IDX_MOVE_2ND);
        wr_addr_out <= dst_addr;
        wr_data_out <= src_byte;
      end
    end
  end

  // pointer updates, one per entry
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_ptr
      always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          ptr[p] <= esie_pkg::ADDR_ZERO;
        end else if (p == 2 && is_push) begin
          ptr[p] <= ptr[p] - esie_pkg::ONE_ADDR;
        // select 0..2 subtracts; select 11 hits pointer two
        end else if (is_sub && (sel == 2'(p) ||
                     (p == 2 && sel == esie_pkg::SEL_RETURN))) begin
          ptr[p] <= ptr[p] - lit6;
        end
      end
    end
  endgenerate

  // return loads pc from the stack top
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_load_en_out <= 1'b0;
      pc_load_out    <= 21'h00_0000;
    end else begin
      pc_load_en_out <= is_sub && sel == esie_pkg::SEL_RETURN;
      if (is_sub && sel == esie_pkg::SEL_RETURN) begin
        pc_load_out <= stack_top_in;
      end
    end
  end

  // flags never written; busy mirrors the second cycle
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_we_out <= 1'b0;
      busy_out     <= 1'b0;
      ptr0_out     <= esie_pkg::ADDR_ZERO;
      ptr1_out     <= esie_pkg::ADDR_ZERO;
      ptr2_out     <= esie_pkg::ADDR_ZERO;
    end else begin
      flags_we_out <= 1'b0;
      busy_out     <= is_move ||
                      (is_sub && sel == esie_pkg::SEL_RETURN);
      ptr0_out     <= ptr[0];
      ptr1_out     <= ptr[1];
      ptr2_out     <= ptr[2];
    end
  end

  // checks
  a_push_write: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    is_push |=> wr_en_out && wr_addr_out == $past(ptr[2]) &&
                wr_data_out == $past(instr_in[7:0]))
    else $error("push literal not written at pointer two");
  a_push_dec: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    is_push |=> ptr[2] == $past(ptr[2]) - esie_pkg::ONE_ADDR)
    else $error("pointer two not decremented after push");
  a_sub_ptr: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    is_sub && sel == esie_pkg::SEL_PTR0 |=>
    ptr[0] == $past(ptr[0]) - $past(lit6))
    else $error("pointer zero subtract wrong");
  a_ret_pc: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    is_sub && sel == esie_pkg::SEL_RETURN |=>
    pc_load_en_out && pc_load_out == $past(stack_top_in) &&
    ptr[2] == $past(ptr[2]) - $past(lit6))
    else $error("return did not subtract and load pc");
  a_ret_two: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    is_sub && sel == esie_pkg::SEL_RETURN |=>
    state == esie_pkg::ESIE_RET ##1 idle)
    else $error("return not two cycles");
  a_move_read: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    is_move && !src_ind |=> rd_en_out && rd_addr_out == $past(src_addr))
    else $error("move source address wrong");
  a_move_two: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    is_move |=> !idle ##1 idle)
    else $error("move not two cycles");
  a_bad_dest: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    state == esie_pkg::ESIE_MOVE && (dst_bad || dst_ind) |=> !wr_en_out)
    else $error("forbidden or indirect destination written");
  a_flags_off: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    !flags_we_out)
    else $error("status flags written");
  c_push: cover property (@(posedge mclk_in) disable iff (!rstn_in)
    is_push);
  c_move: cover property (@(posedge mclk_in) disable iff (!rstn_in)
    is_move ##1 wr_en_out);
  c_ret: cover property (@(posedge mclk_in) disable iff (!rstn_in)
    is_sub && sel == esie_pkg::SEL_RETURN);
endmodule

//--- rtl/esie_pkg.sv
// esie_pkg: constants, opcodes and states of the extended stack executor
package esie_pkg;
  localparam int unsigned ADDR_W   = 12;             // data space width
  localparam int unsigned WORD_W   = 16;             // program word width
  localparam int unsigned DATA_W   = 8;              // data byte width
  localparam int unsigned PC_W     = 21;             // program counter width
  localparam logic [8:0]  OP_IDX_MOVE = 9'h1d7;      // 1110_1011_1 prefix
  localparam logic [3:0]  OP_IDX_MOVE_2ND = 4'hf;    // second word prefix
  localparam logic [7:0]  OP_PUSH_LIT = 8'hfa;       // 1111_1010
  localparam logic [7:0]  OP_SUB_PTR  = 8'he9;       // 1110_1001
  localparam logic [1:0]  SEL_RETURN  = 2'h3;        // select 11 means return
  localparam logic [1:0]  SEL_PTR0    = 2'h0;        // pointer zero
  localparam logic [1:0]  SEL_PTR1    = 2'h1;        // pointer one
  localparam logic [11:0] ADDR_ZERO   = 12'h000;     // pointer reset value
  localparam logic [7:0]  DATA_ZERO   = 8'h00;       // indirect read value
  localparam logic [11:0] ONE_ADDR    = 12'h001;     // push decrement
  // special function register addresses (defaults, not from the data)
  localparam logic [11:0] ADDR_PC_LOW     = 12'hff9; // program_counter_low
  localparam logic [11:0] ADDR_TOP_LOW    = 12'hffd; // return_top_low
  localparam logic [11:0] ADDR_TOP_HIGH   = 12'hffe; // return_top_high
  localparam logic [11:0] ADDR_TOP_UPPER  = 12'hfff; // return_top_upper
  // indirect-addressing register block (base, mask)
  localparam logic [11:0] IND_MASK    = 12'hff8;     // compare mask
  localparam logic [11:0] IND_BASE0   = 12'hfe8;     // group for pointer 0
  localparam logic [11:0] IND_BASE1   = 12'hfe0;     // group for pointer 1
  localparam logic [11:0] IND_BASE2   = 12'hfd8;     // group for pointer 2
  localparam logic [2:0]  IND_LOW_MAX = 3'h4;        // offsets 0..4 indirect

  // execution phase; idle 00, move 01, ret 11
  typedef enum logic [1:0] {
    ESIE_IDLE = 2'b00,                               // decoding
    ESIE_MOVE = 2'b01,                               // second move cycle
    ESIE_RET  = 2'b11                                // return dead cycle
  } esie_state_t;
endpackage

//--- rtl/esie_ind_detect.sv
// esie_ind_detect: flags addresses inside indirect-addressing register groups
`timescale 1ns/100ps
module esie_ind_detect (
  input  wire logic [11:0] addr_in,   // address to classify
  output logic             hit_out    // high when indirect register
);
  logic [2:0] grp_hit;                // per-group match

  // one comparator per pointer group
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_grp
      logic [11:0] base;              // group base
      assign base = (g == 0) ? esie_pkg::IND_BASE0 :
                    (g == 1) ? esie_pkg::IND_BASE1 : esie_pkg::IND_BASE2;
      assign grp_hit[g] = ((addr_in & esie_pkg::IND_MASK) == base) &&
                          (addr_in[2:0] <= esie_pkg::IND_LOW_MAX);
    end
  endgenerate

  assign hit_out = |grp_hit;
endmodule

//--- sim/tb.sv
// tb: self-checking bench for the extended stack executor
`timescale 1ns/100ps
module tb;
  logic        mclk_in, rstn_in, instr_vld_in; // clock, reset, word valid
  logic [15:0] instr_in;                       // program word
  logic [7:0]  rd_data_in, wr_data_out;        // memory data
  logic [20:0] stack_top_in, pc_load_out;      // return address paths
  logic [11:0] rd_addr_out, wr_addr_out;       // memory addresses
  logic [11:0] ptr0_out, ptr1_out, ptr2_out;   // pointer views
  logic        rd_en_out, wr_en_out, pc_load_en_out, flags_we_out, busy_out;
  int          fail_count, comparisons;        // verdict counters
  int          cyc, tn;                        // cycle index, result cycle
  int unsigned seed = 85468;                   // xorshift state
  logic [20:0] st;                             // stack top just driven
  int          ptr[3];                         // model pointers
  int          ewa[int], ewd[int], era[int], epc[int]; // expected events
  bit          ebusy[int];                     // busy cycles
  // offsets aimed at refused, indirect and wrapping addresses
  logic [13:0] mv[10] = '{{7'd0, 7'd56}, {7'd1, 7'd60}, {7'd2, 7'd62},
    {7'd40, 7'd23}, {7'd127, 7'd100}, {7'd5, 7'd6}, {7'd31, 7'd42},
    {7'd10, 7'd30}, {7'd39, 7'd44}, {7'd62, 7'd61}};

  esie_core i_esie_core (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .instr_vld_in(instr_vld_in), .instr_in(instr_in),
    .rd_data_in(rd_data_in), .stack_top_in(stack_top_in),
    .rd_addr_out(rd_addr_out), .rd_en_out(rd_en_out),
    .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
    .wr_en_out(wr_en_out), .ptr0_out(ptr0_out), .ptr1_out(ptr1_out),
    .ptr2_out(ptr2_out), .pc_load_out(pc_load_out),
    .pc_load_en_out(pc_load_en_out), .flags_we_out(flags_we_out),
    .busy_out(busy_out));

  // free-running 50 MHz clock and cycle index
  initial begin
    mclk_in = 0;
    forever #10 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) cyc <= cyc + 1;

  function int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // indirect-register groups: five slots at each base
  function automatic bit ind(int a);
    logic [11:0] v;
    v = 12'(a);
    return ((v & esie_pkg::IND_MASK) == esie_pkg::IND_BASE0 ||
            (v & esie_pkg::IND_MASK) == esie_pkg::IND_BASE1 ||
            (v & esie_pkg::IND_MASK) == esie_pkg::IND_BASE2) &&
           v[2:0] <= esie_pkg::IND_LOW_MAX;
  endfunction

  // automatic: the pointer check and the monitor share a negedge
  task automatic chk(bit ok, string m);
    comparisons++;
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task test_done();
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one word per edge; result shows two cycles later
  task put(logic [15:0] w, bit v, logic [7:0] d);
    @(posedge mclk_in);
    st = 21'(rnd());
    instr_vld_in <= v;
    instr_in     <= w;
    rd_data_in   <= d;
    stack_top_in <= st;
    tn = cyc + 2;
  endtask

  task op_push(logic [7:0] k);
    put({esie_pkg::OP_PUSH_LIT, k}, 1, 8'(rnd()));
    ewa[tn] = ptr[2];
    ewd[tn] = k;
    ptr[2] = (ptr[2] - 1) & 'hfff;
  endtask

  // select 3 is the return form; a push is offered in its dead cycle
  task op_sub(logic [1:0] s, logic [5:0] k);
    int i;
    i = (s == esie_pkg::SEL_RETURN) ? 2 : s;
    put({esie_pkg::OP_SUB_PTR, s, k}, 1, 8'(rnd()));
    ptr[i] = (ptr[i] - k) & 'hfff;
    if (s == esie_pkg::SEL_RETURN) begin
      epc[tn] = st;
      ebusy[tn] = 1;
      put({esie_pkg::OP_PUSH_LIT, 8'(rnd())}, 1, 8'(rnd()));
    end
  endtask

  // read data is only valid while the second word is shown
  // bad second word: prefix not ones, so nothing may be written
  task op_move(logic [6:0] zs, logic [6:0] zd, bit bad = 0);
    int s, d;
    logic [7:0] v;
    s = (ptr[2] + zs) & 'hfff;
    d = (ptr[2] + zd) & 'hfff;
    v = 8'(rnd());
    put({esie_pkg::OP_IDX_MOVE, zs}, 1, 8'(rnd()));
    // indirect source: read suppressed, zero used instead
    if (!ind(s)) era[tn] = s;
    ebusy[tn] = 1;
    put({(bad ? 4'h0 : esie_pkg::OP_IDX_MOVE_2ND), 5'(rnd()), zd}, 1, v);
    if (!bad && !ind(d) && d != esie_pkg::ADDR_PC_LOW &&
        d < esie_pkg::ADDR_TOP_LOW) begin
      ewa[tn] = d;
      ewd[tn] = ind(s) ? 0 : v;
    end
  endtask

  // pointers lag a cycle, so let the pipe drain first
  task idle_chk();
    repeat (3) put(16'(rnd()), 0, 8'(rnd()));
    @(negedge mclk_in);
    chk(ptr0_out === 12'(ptr[0]) && ptr1_out === 12'(ptr[1]) &&
        ptr2_out === 12'(ptr[2]), "pointer mismatch");
  endtask

  // compare write, read, pc load, busy and flag ports against the model each cycle
  always @(negedge mclk_in) begin
    if (rstn_in) begin
      if (ewa.exists(cyc)) chk(wr_en_out === 1'b1 &&
        wr_addr_out === 12'(ewa[cyc]) && wr_data_out === 8'(ewd[cyc]),
        "bad write");
      else chk(wr_en_out === 1'b0, "stray write"); // refused
      if (era.exists(cyc)) chk(rd_en_out === 1'b1 && // address
        rd_addr_out === 12'(era[cyc]), "bad read");
      else chk(rd_en_out === 1'b0, "stray read");
      if (epc.exists(cyc)) chk(pc_load_en_out === 1'b1 && // load
        pc_load_out === 21'(epc[cyc]), "bad return");
      else chk(pc_load_en_out === 1'b0, "stray pc load");
      chk(busy_out === 1'(ebusy.exists(cyc)), "busy mismatch");
      chk(flags_we_out === 1'b0, "flags written"); // untouched
    end
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    rstn_in = 0;
    instr_vld_in = 0;
    instr_in = 16'h0000;
    rd_data_in = 8'h00;
    stack_top_in = 21'h0_0000;
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1;
    repeat (3) op_push(8'(rnd())); // wrap below zero
    op_sub(2'h2, 6'd60); // pointer two to FC1
    foreach (mv[i]) op_move(mv[i][13:7], mv[i][6:0]);
    op_move(7'd5, 7'd6, 1); // bad second word
    repeat (6) op_move(7'(rnd()), 7'(rnd())); // random moves
    idle_chk();
    op_sub(esie_pkg::SEL_RETURN, 6'd63); // top literal
    op_sub(esie_pkg::SEL_RETURN, 6'(rnd())); // random literal
    for (int s = 0; s < 3; s++) begin
      op_sub(2'(s), 6'd63); // each select
      op_sub(2'(s), 6'd0);
      op_sub(2'(s), 6'(rnd()));
    end
    repeat (4) op_push(8'(rnd())); // back to back
    idle_chk();
    test_done();
  end
endmodule
